// ---- core/sbd_top.sv ----
// sync barrier decode and completion control with wishbone status
`timescale 1ns/1ns
`default_nettype none
module sbd_top
  import sbd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire sbd_issue_t issue_i,
  output logic issue_ready_o,
  output logic stall_o,
  output sbd_req_t mem_req_o,
  input wire logic mem_ack_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  typedef enum logic [1:0] {
    S_IDLE,
    S_WAIT
  } sbd_state_t;

  typedef struct packed {
    sbd_state_t state;
    sbd_req_t req;
    logic stall;
    logic ready;
    logic force_full;
    logic [15:0] count;
    logic [31:0] rdata;
    logic ack;
  } sbd_regs_t;

  sbd_regs_t r_r;
  sbd_regs_t r_nxt;

  sbd_dom_t map_dom;
  sbd_typ_t map_typ;
  logic map_alias;

  sbd_option_map u_map (
    .option_i(issue_i.option),
    .domain_o(map_dom),
    .types_o(map_typ),
    .alias_o(map_alias)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic guest;
    logic is_hyp;
    sbd_dom_t dom;
    sbd_typ_t typ;
    guest = 1'b0;
    is_hyp = 1'b0;
    dom = map_dom;
    typ = map_typ;
    r_nxt = r_r;
    r_nxt.ack = 1'b0;
    r_nxt.req.valid = 1'b0;

    is_hyp = (issue_i.cur_level == LVL_HYP);
    guest = issue_i.hyp_present && !issue_i.secure &&
            (issue_i.cur_level == LVL_USER || issue_i.cur_level == LVL_KERNEL);
    if (guest) begin
      if (issue_i.upgrade == UPG_FULL) begin
        dom = DOM_FULL;
      end else if (issue_i.upgrade == UPG_OUTER && dom != DOM_FULL) begin
        dom = DOM_OUTER;
      end else if (issue_i.upgrade == UPG_INNER && dom == DOM_LOCAL) begin
        dom = DOM_INNER;
      end
    end
    // software debug override: widen every barrier to full system all
    if (r_r.force_full) begin
      dom = DOM_FULL;
      typ = TYP_ALL;
    end

    case (r_r.state)
      S_IDLE: begin
        if (issue_i.valid && issue_i.cond_pass) begin
          r_nxt.req.valid = 1'b1;
          r_nxt.req.full_barrier = map_alias && is_hyp;
          r_nxt.req.domain = dom;
          r_nxt.req.types = typ;
          // full barrier spans all levels and machine ids
          r_nxt.req.match_vm_id = !is_hyp;
          r_nxt.req.hyp_only = is_hyp && !map_alias;
          r_nxt.req.virtual_machine_id = issue_i.virtual_machine_id;
          r_nxt.stall = 1'b1;
          r_nxt.ready = 1'b0;
          r_nxt.state = S_WAIT;
        end
      end
      S_WAIT: begin
        // held until memory reports every covered access done
        if (mem_ack_i) begin
          r_nxt.stall = 1'b0;
          r_nxt.ready = 1'b1;
          r_nxt.count = r_r.count + 16'h0001;
          r_nxt.state = S_IDLE;
        end
      end
      default: begin
        r_nxt.state = S_IDLE;
      end
    endcase

    // wishbone slave, one wait state, ack dropped after one cycle
    if (wb_cyc_i && wb_stb_i && !r_r.ack) begin
      r_nxt.ack = 1'b1;
      r_nxt.rdata = 32'h0000_0000;
      if (wb_adr_i == ADR_CTRL) begin
        if (wb_we_i && wb_sel_i[0]) begin
          r_nxt.force_full = wb_dat_i[0];
        end
        r_nxt.rdata = {31'h0, r_r.force_full};
      end else if (wb_adr_i == ADR_STAT) begin
        r_nxt.rdata = {24'h0, r_r.req.domain, r_r.req.types,
                       2'h0, r_r.req.full_barrier, r_r.stall};
      end else if (wb_adr_i == ADR_CNT) begin
        r_nxt.rdata = {16'h0, r_r.count};
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_r <= '{state: S_IDLE,
               req: '{valid: 1'b0, full_barrier: 1'b0, domain: DOM_FULL,
                      types: TYP_ALL, match_vm_id: 1'b0, hyp_only: 1'b0,
                      virtual_machine_id: VM_ID_RST},
               stall: 1'b0, ready: 1'b1, force_full: 1'b0,
               count: 16'h0000, rdata: 32'h0000_0000, ack: 1'b0};
    end else begin
      r_r <= r_nxt;
    end
  end

  assign issue_ready_o = r_r.ready;
  assign stall_o = r_r.stall;
  assign mem_req_o = r_r.req;
  assign wb_dat_o = r_r.rdata;
  assign wb_ack_o = r_r.ack;

endmodule
`default_nettype wire

// ---- core/sbd_pkg.sv ----
// package: constants and types for the sync barrier option decoder
// Function
// - options 1111/1110/1101 give full system: all, writes, reads-A
// - options 1011/1010/1001 give inner shareable: all, writes, reads-A
// - options 0111/0110/0101 give non-shareable: all, writes, reads-A
// - options 0011/0010/0001 give outer shareable: all, writes, reads-A
// - option 1100 is the full barrier alias, else full system all
// - reserved or unimplemented options run as full system all barrier
// - full system all and alias always supported; others may fall back
// - failed condition check issues no barrier request at all
// - guest with upgrade field 11 forces full system domain
// - guest with upgrade field 10 raises non-full domains to outer
// - guest with upgrade field 01 raises non-shareable to inner
// - option 1100 at hyp level performs a full barrier
// - full barrier at hyp level ignores level and machine id
// - alias at kernel or user level equals full system all barrier
// - full barrier finishes only after covered accesses complete
// - user or kernel barrier orders only same virtual machine id
// - hyp level barrier other than option 1100 orders only against hyp level accesses
package sbd_pkg;

  // ----------------------------------------------------------------
  // option encodings
  // ----------------------------------------------------------------
  localparam logic [3:0] OPT_FULL_ALL = 4'hf;
  localparam logic [3:0] OPT_FULL_WR = 4'he;
  localparam logic [3:0] OPT_FULL_RD = 4'hd;
  localparam logic [3:0] OPT_ALIAS = 4'hc;
  localparam logic [3:0] OPT_INNER_ALL = 4'hb;
  localparam logic [3:0] OPT_INNER_WR = 4'ha;
  localparam logic [3:0] OPT_INNER_RD = 4'h9;
  localparam logic [3:0] OPT_LOCAL_ALL = 4'h7;
  localparam logic [3:0] OPT_LOCAL_WR = 4'h6;
  localparam logic [3:0] OPT_LOCAL_RD = 4'h5;
  localparam logic [3:0] OPT_OUTER_ALL = 4'h3;
  localparam logic [3:0] OPT_OUTER_WR = 4'h2;
  localparam logic [3:0] OPT_OUTER_RD = 4'h1;

  // ----------------------------------------------------------------
  // upgrade field values and exception levels
  // ----------------------------------------------------------------
  localparam logic [1:0] UPG_NONE = 2'h0;
  localparam logic [1:0] UPG_INNER = 2'h1;
  localparam logic [1:0] UPG_OUTER = 2'h2;
  localparam logic [1:0] UPG_FULL = 2'h3;
  localparam logic [1:0] LVL_USER = 2'h0;
  localparam logic [1:0] LVL_KERNEL = 2'h1;
  localparam logic [1:0] LVL_HYP = 2'h2;

  // set of options this core implements natively; others fall back
  localparam logic [15:0] OPT_SUPPORTED = 16'hfeee;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] ADR_CTRL = 4'h0;
  localparam logic [3:0] ADR_STAT = 4'h4;
  localparam logic [3:0] ADR_CNT = 4'h8;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DOM_LOCAL,
    DOM_INNER,
    DOM_OUTER,
    DOM_FULL
  } sbd_dom_t;

  typedef enum logic [1:0] {
    TYP_ALL,
    TYP_WRITES,
    TYP_READS
  } sbd_typ_t;

  typedef struct packed {
    logic valid;
    logic [3:0] option;
    logic cond_pass;
    logic [1:0] cur_level;
    logic secure;
    logic hyp_present;
    logic [1:0] upgrade;
    logic [7:0] virtual_machine_id;
  } sbd_issue_t;

  typedef struct packed {
    logic valid;
    logic full_barrier;
    sbd_dom_t domain;
    sbd_typ_t types;
    logic match_vm_id;
    logic hyp_only;
    logic [7:0] virtual_machine_id;
  } sbd_req_t;

  localparam logic [7:0] VM_ID_RST = 8'h00;

endpackage

// ---- core/sbd_option_map.sv ----
// option field to domain and access type mapping
`timescale 1ns/1ns
`default_nettype none
module sbd_option_map
  import sbd_pkg::*;
(
  input wire logic [3:0] option_i,
  output sbd_dom_t domain_o,
  output sbd_typ_t types_o,
  output logic alias_o
);

  logic [3:0] opt;

  always_comb begin
    // unsupported options are folded onto full system all
    opt = OPT_SUPPORTED[option_i] ? option_i : OPT_FULL_ALL;
    alias_o = (option_i == OPT_ALIAS);
    domain_o = DOM_FULL;
    types_o = TYP_ALL;
    case (opt)
      OPT_FULL_WR: begin
        types_o = TYP_WRITES;
      end
      OPT_FULL_RD: begin
        types_o = TYP_READS;
      end
      OPT_INNER_ALL: begin
        domain_o = DOM_INNER;
      end
      OPT_INNER_WR: begin
        domain_o = DOM_INNER;
        types_o = TYP_WRITES;
      end
      OPT_INNER_RD: begin
        domain_o = DOM_INNER;
        types_o = TYP_READS;
      end
      OPT_LOCAL_ALL: begin
        domain_o = DOM_LOCAL;
      end
      OPT_LOCAL_WR: begin
        domain_o = DOM_LOCAL;
        types_o = TYP_WRITES;
      end
      OPT_LOCAL_RD: begin
        domain_o = DOM_LOCAL;
        types_o = TYP_READS;
      end
      OPT_OUTER_ALL: begin
        domain_o = DOM_OUTER;
      end
      OPT_OUTER_WR: begin
        domain_o = DOM_OUTER;
        types_o = TYP_WRITES;
      end
      OPT_OUTER_RD: begin
        domain_o = DOM_OUTER;
        types_o = TYP_READS;
      end
      default: begin
        domain_o = DOM_FULL;
        types_o = TYP_ALL;
      end
    endcase
  end

endmodule
`default_nettype wire

// ---- tb/sbd_top_assertions.sv ----
// checker: timing and decode relations at the barrier decoder ports
`timescale 1ns/1ns
`default_nettype none
module sbd_top_assertions
  import sbd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire sbd_issue_t issue_i,
  input wire logic issue_ready_o,
  input wire logic stall_o,
  input wire sbd_req_t mem_req_o,
  input wire logic mem_ack_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take; issue_i.valid && issue_i.cond_pass && !stall_o; endsequence
  sequence s_guest;
    s_take ##0 issue_i.hyp_present && !issue_i.secure &&
      (issue_i.cur_level == LVL_USER || issue_i.cur_level == LVL_KERNEL);
  endsequence
  property p_issue; s_take |=> mem_req_o.valid && stall_o && !issue_ready_o; endproperty
  a_issue: assert property (p_issue) else $error("no request after issue");
  property p_fail;
    issue_i.valid && !issue_i.cond_pass && !stall_o |=> !stall_o && !mem_req_o.valid;
  endproperty
  a_fail: assert property (p_fail) else $error("request on failed check");
  property p_pulse; mem_req_o.valid |=> !mem_req_o.valid; endproperty
  a_pulse: assert property (p_pulse) else $error("request longer than one cycle");
  property p_hold; stall_o && !mem_ack_i |=> stall_o && !issue_ready_o; endproperty
  a_hold: assert property (p_hold) else $error("stall dropped early");
  property p_done; stall_o && mem_ack_i |=> !stall_o && issue_ready_o; endproperty
  a_done: assert property (p_done) else $error("stall kept after ack");
  property p_alias;
    s_take ##0 issue_i.option == OPT_ALIAS && issue_i.cur_level == LVL_HYP
      |=> mem_req_o.full_barrier && !mem_req_o.match_vm_id && !mem_req_o.hyp_only;
  endproperty
  a_alias: assert property (p_alias) else $error("hyp alias not full");
  property p_rsv;
    s_take ##0 issue_i.option[1:0] == 2'h0 |=> mem_req_o.domain == DOM_FULL
      && mem_req_o.types == TYP_ALL;
  endproperty
  a_rsv: assert property (p_rsv) else $error("fallback not full all");
  property p_bsu; s_guest ##0 issue_i.upgrade == UPG_FULL |=> mem_req_o.domain == DOM_FULL;
  endproperty
  a_bsu: assert property (p_bsu) else $error("upgrade not full");
  property p_outer;
    s_guest ##0 issue_i.upgrade == UPG_OUTER
      |=> mem_req_o.domain inside {DOM_OUTER, DOM_FULL};
  endproperty
  a_outer: assert property (p_outer) else $error("upgrade not outer");
  property p_guest_vm;
    s_take ##0 issue_i.cur_level != LVL_HYP
      |=> mem_req_o.match_vm_id && !mem_req_o.hyp_only && !mem_req_o.full_barrier;
  endproperty
  a_guest_vm: assert property (p_guest_vm) else $error("guest barrier scope wrong");
  property p_wb; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_wb: assert property (p_wb) else $error("bus ack timing");
endmodule
bind sbd_top sbd_top_assertions i_chk(.clk_i, .rst_i, .issue_i, .issue_ready_o, .stall_o,
  .mem_req_o, .mem_ack_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o);
`default_nettype wire

// ---- tb/sbd_mem_model.sv ----
// memory side model: acks each barrier after a set delay
`timescale 1ns/1ns
`default_nettype none
module sbd_mem_model
  import sbd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire sbd_req_t req_i,
  input wire logic [3:0] delay_i,
  output logic ack_o
);
  logic [4:0] cnt_r;
  // ack only once the covered accesses have drained
  always_ff @(posedge clk_i) begin
    if (rst_i) cnt_r <= 5'h00;
    else if (req_i.valid) cnt_r <= {1'h0, delay_i} + 5'h01;
    else if (cnt_r != 5'h00) cnt_r <= cnt_r - 5'h01;
  end
  assign ack_o = (cnt_r == 5'h01);
endmodule
`default_nettype wire

// ---- tb/test_sync_barrier_option_decode.sv ----
// self-checking bench for the barrier decoder
`timescale 1ns/1ns
`default_nettype none
module test_sync_barrier_option_decode
  import sbd_pkg::*;
;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic frc = 1'b0;
  logic issue_ready_o, stall_o, mem_ack_i, wb_ack_o;
  logic [3:0] wb_adr_i = 4'h0, dly = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  sbd_issue_t issue_i = '0;
  sbd_req_t mem_req_o;
  int error_cnt = 0, cmp_count = 0;
  sbd_dom_t dm[4] = '{DOM_OUTER, DOM_LOCAL, DOM_INNER, DOM_FULL};
  sbd_typ_t tm[4] = '{TYP_ALL, TYP_READS, TYP_WRITES, TYP_ALL};
  always #5 clk_i = ~clk_i;
  sbd_top i_dut(.clk_i, .rst_i, .issue_i, .issue_ready_o, .stall_o, .mem_req_o, .mem_ack_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o);
  sbd_mem_model i_mem(.clk_i, .rst_i, .req_i(mem_req_o), .delay_i(dly), .ack_o(mem_ack_i));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task results;
    $display("mismatches %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 20);
    if (wb_ack_o !== 1'b1) begin
      error_cnt++;
      results();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
  endtask
  // -----------------------------------------------------------
  // one barrier: issue, compare request, wait for completion
  // -----------------------------------------------------------
  task automatic bar(input logic [3:0] o, input logic [1:0] l, input logic s,
    input logic [1:0] u, input logic c, input logic h);
    sbd_dom_t d;
    sbd_typ_t t;
    int i;
    d = (o[1:0] == 2'h0) ? DOM_FULL : dm[o[3:2]];
    t = tm[o[1:0]];
    if (h && !s && l != LVL_HYP) begin
      if (u == UPG_FULL) d = DOM_FULL;
      if (u == UPG_OUTER && d != DOM_FULL) d = DOM_OUTER;
      if (u == UPG_INNER && d == DOM_LOCAL) d = DOM_INNER;
    end
    if (frc) d = DOM_FULL;
    if (frc) t = TYP_ALL;
    @(posedge clk_i);
    issue_i <= '{1'b1, o, c, l, s, h, u, 8'h5a};
    dly <= {1'b0, o[2:0]};
    @(posedge clk_i);
    issue_i.valid <= 1'b0;
    #1;
    chk("req", mem_req_o.valid, c);
    if (c) begin
      chk("dom", mem_req_o.domain, d);
      chk("typ", mem_req_o.types, t);
      chk("fb", mem_req_o.full_barrier, o == OPT_ALIAS && l == LVL_HYP);
      chk("vm", {mem_req_o.match_vm_id, mem_req_o.hyp_only},
        {l != LVL_HYP, l == LVL_HYP && o != OPT_ALIAS});
      chk("virtual_machine_id", mem_req_o.virtual_machine_id, 8'h5a);
    end
    i = 0;
    while (stall_o === 1'b1 && i < 40) begin
      @(posedge clk_i);
      #1;
      i++;
    end
    chk("stall", stall_o, 1'b0);
    if (stall_o !== 1'b0) results();
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    #1;
    chk("rst", {stall_o, issue_ready_o, mem_req_o.valid}, 3'b010);
    for (int p = 0; p < 4; p++)
      for (int u = 0; u < 4; u++)
        for (int o = 0; o < 16; o++)
          bar(o[3:0], (p == 3) ? LVL_KERNEL : p[1:0], p == 3, u[1:0], 1'b1, 1'b1);
    bar(4'hf, LVL_USER, 1'b0, UPG_NONE, 1'b0, 1'b1);
    wb(1'b0, ADR_CNT, 32'h0);
    chk("cnt", rd, 32'h100);
    // no hypervisor level: the upgrade field must have no effect
    bar(4'h7, LVL_USER, 1'b0, UPG_FULL, 1'b1, 1'b0);
    wb(1'b1, ADR_CTRL, 32'h1);
    wb(1'b0, ADR_CTRL, 32'h0);
    chk("ctrl", rd, 32'h1);
    frc = 1'b1;
    bar(4'h6, LVL_USER, 1'b0, UPG_NONE, 1'b1, 1'b1);
    wb(1'b0, 4'h4, 32'h0);
    chk("stat", rd, 32'hc0);
    wb(1'b0, 4'hc, 32'h0);
    chk("unmapped", rd, 32'h0);
    results();
  end
  initial begin
    #200000;
    error_cnt++;
    results();
  end
endmodule
`default_nettype wire
